// ===== nv_ctrl_pkg.sv
// Purpose: Shared constants and types for the nonvolatile store/recall host.
// Assumes: 40 MHz clock; one external 32K x 8 nonvolatile SRAM.
// Notes: Long waits are derived here; the top module may override them.
`default_nettype none

package nv_ctrl_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W = 20;
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned SEQ_LAST = 5;

  // ---------------------------------------------------------------
  // Timing, figures in their own units
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned T_ACCESS_NS = 35;
  localparam int unsigned T_CE_HIGH_NS = 25;
  localparam int unsigned T_STORE_MS = 10;
  localparam int unsigned T_RECALL_US = 20;
  localparam int unsigned T_LINE_PULSE_NS = 100;

  // Least times round up; pin data arrive through the synchroniser
  localparam int unsigned ACC_CYC =
    (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
  localparam int unsigned GAP_CYC = (T_CE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STORE_CYC =
    (T_STORE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECALL_CYC =
    (T_RECALL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LINE_PULSE_CYC =
    (T_LINE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;

  // ---------------------------------------------------------------
  // Initiation sequence addresses
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] SEQ_A0 = 15'h0e38;
  localparam logic [ADDR_W-1:0] SEQ_A1 = 15'h31c7;
  localparam logic [ADDR_W-1:0] SEQ_A2 = 15'h03e0;
  localparam logic [ADDR_W-1:0] SEQ_A3 = 15'h3c1f;
  localparam logic [ADDR_W-1:0] SEQ_A4 = 15'h303f;
  localparam logic [ADDR_W-1:0] SEQ_STORE = 15'h0fc0;
  localparam logic [ADDR_W-1:0] SEQ_RECALL = 15'h0c63;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_WRITE = 3'h1,
    OP_STORE = 3'h2,
    OP_RECALL = 3'h3,
    OP_LINE_STORE = 3'h4
  } op_t;

  typedef struct packed {
    op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cmd_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address_lines;
    logic chip_en_n;
    logic write_en_n;
    logic out_en_n;
  } sram_pins_t;

endpackage

`default_nettype wire

// ===== pin_sync.sv
// Purpose: Two-stage synchroniser for a bundle of pin inputs.
// Assumes: Each bit is an independent level.
// Notes: Multi-bit data only sampled after it has settled at the pins.
`timescale 1ns/1ps
`default_nettype none

module pin_sync
  import nv_ctrl_pkg::*;
#(
  parameter int unsigned WIDTH = 1
)
(
  input wire logic clk, // System clock
  input wire logic rst, // Sync reset, high
  input wire logic [WIDTH-1:0] pin_in, // Asynchronous pins
  output logic [WIDTH-1:0] sync_out // Synchronised levels
);

  // ---------------------------------------------------------------
  // Per-bit flop pairs
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      logic meta_r;
      logic stable_r;
      // First flop feeds only the second
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          meta_r <= 1'b1;
          stable_r <= 1'b1;
        end
        else
        begin
          meta_r <= pin_in[gi];
          stable_r <= meta_r;
        end
      end
      assign sync_out[gi] = stable_r;
    end
  endgenerate

endmodule

`default_nettype wire

// ===== nv_store_host.sv
// Purpose: Host controller driving a nonvolatile SRAM: reads, writes,
//          software store/recall sequences and line-requested stores.
// Assumes: Sole master of the SRAM bus; pins are asynchronous to clk.
// Notes: Long waits are parameters so simulation can shorten them.
//
// Contract
// - Store: six reads ending at 0FC0
// - No foreign access inside the sequence
// - Sequence accesses are reads only
// - Recall: same five, then 0C63
// - Hold line low past pulse width
// - Shared line: drive low only, never high
// - Chip select clocks sequence, write high
`timescale 1ns/1ps
`default_nettype none

module nv_store_host
  import nv_ctrl_pkg::*;
#(
  parameter int unsigned STORE_WAIT = STORE_CYC,
  parameter int unsigned RECALL_WAIT = RECALL_CYC
)
(
  input wire logic clk, // 40 MHz clock
  input wire logic rst, // Sync reset, high
  input wire logic cmd_valid, // Command offered
  output logic cmd_ready, // Command taken this cycle
  input wire cmd_t cmd, // Operation, address, write data
  output logic rsp_valid, // One-cycle completion pulse, none for writes
  output logic [DATA_W-1:0] rsp_rdata, // Read data, registered
  output logic busy, // Operation in progress
  output sram_pins_t pins, // Address and strobes
  input wire logic [DATA_W-1:0] data_lines_i, // Data pins in
  output logic [DATA_W-1:0] data_lines_o, // Data pins out
  output logic data_lines_oe_n, // Data drive enable, low drives
  input wire logic store_busy_line_n_i, // Shared line level
  output logic store_busy_line_n_o, // Shared line drive value
  output logic store_busy_line_n_oe_n // Shared line enable, low drives
);

  // ---------------------------------------------------------------
  // Types and sequence decode
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ACC = 3'b001,
    ST_GAP = 3'b010,
    ST_PULSE = 3'b011,
    ST_NVWAIT = 3'b100,
    ST_RELWAIT = 3'b101
  } state_t;

  // Address of each step of the initiation sequence
  function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] idx,
                                                 input logic recall);
    logic [ADDR_W-1:0] a;
    a = SEQ_A0;
    case (idx)
      3'h0: a = SEQ_A0;
      3'h1: a = SEQ_A1;
      3'h2: a = SEQ_A2;
      3'h3: a = SEQ_A3;
      3'h4: a = SEQ_A4;
      3'h5: a = recall ? SEQ_RECALL : SEQ_STORE;
      default: a = SEQ_A0;
    endcase
    return a;
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic seq_r, seq_nxt;
  logic recall_r, recall_nxt;
  logic write_r, write_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic rsp_r, rsp_nxt;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [DATA_W:0] sync_q;
  wire logic [DATA_W-1:0] data_s;
  wire logic line_high_s;

  pin_sync #(
    .WIDTH(DATA_W + 1)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .pin_in({store_busy_line_n_i, data_lines_i}),
    .sync_out(sync_q)
  );

  assign data_s = sync_q[DATA_W-1:0];
  assign line_high_s = sync_q[DATA_W];

  // ---------------------------------------------------------------
  // Decodes
  // ---------------------------------------------------------------
  wire logic cnt_done;
  wire logic take;
  wire logic seq_more;
  wire logic in_acc;
  wire logic [CNT_W-1:0] acc_load;
  wire logic [CNT_W-1:0] gap_load;
  wire logic [CNT_W-1:0] pulse_load;
  wire logic [CNT_W-1:0] store_load;
  wire logic [CNT_W-1:0] recall_load;

  assign cnt_done = (cnt_r == '0);
  // Device busy or line held: stay off the bus
  assign take = (state_r == ST_IDLE) && cmd_valid && line_high_s;
  assign seq_more = seq_r && (idx_r != SEQ_LAST[2:0]);
  assign in_acc = (state_r == ST_ACC);
  assign acc_load = CNT_W'(ACC_CYC - 1);
  assign gap_load = CNT_W'(GAP_CYC - 1);
  assign pulse_load = CNT_W'(LINE_PULSE_CYC - 1);
  assign store_load = CNT_W'(STORE_WAIT - 1);
  assign recall_load = CNT_W'(RECALL_WAIT - 1);

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_done ? cnt_r : cnt_r - CNT_W'(1);
    idx_nxt = idx_r;
    seq_nxt = seq_r;
    recall_nxt = recall_r;
    write_nxt = write_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    rsp_nxt = 1'b0;
    case (state_r)
      ST_IDLE:
      begin
        if (take)
        begin
          addr_nxt = cmd.addr;
          wdata_nxt = cmd.wdata;
          write_nxt = (cmd.op == OP_WRITE);
          recall_nxt = (cmd.op == OP_RECALL);
          seq_nxt = 1'b0;
          idx_nxt = 3'h0;
          cnt_nxt = acc_load;
          state_nxt = ST_ACC;
          if ((cmd.op == OP_STORE) || (cmd.op == OP_RECALL))
          begin
            write_nxt = 1'b0;
            seq_nxt = 1'b1;
            addr_nxt = seq_addr(3'h0, cmd.op == OP_RECALL);
          end
          else if (cmd.op == OP_LINE_STORE)
          begin
            cnt_nxt = pulse_load;
            state_nxt = ST_PULSE;
          end
        end
      end
      ST_ACC:
      begin
        if (cnt_done)
        begin
          if (!seq_r && !write_r)
          begin
            rdata_nxt = data_s;
            rsp_nxt = 1'b1;
          end
          cnt_nxt = gap_load;
          state_nxt = ST_GAP;
        end
      end
      ST_GAP:
      begin
        if (cnt_done)
        begin
          // Steps follow with no other access between
          if (seq_more)
          begin
            idx_nxt = idx_r + 3'h1;
            addr_nxt = seq_addr(idx_r + 3'h1, recall_r);
            cnt_nxt = acc_load;
            state_nxt = ST_ACC;
          end
          else if (seq_r)
          begin
            cnt_nxt = recall_r ? recall_load : store_load;
            state_nxt = ST_NVWAIT;
          end
          else
          begin
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_PULSE:
      begin
        // Line held past the request width
        if (cnt_done)
        begin
          cnt_nxt = store_load;
          state_nxt = ST_NVWAIT;
        end
      end
      ST_NVWAIT:
      begin
        if (cnt_done)
        begin
          state_nxt = ST_RELWAIT;
        end
      end
      ST_RELWAIT:
      begin
        // Wait for the line to rise again
        if (line_high_s)
        begin
          rsp_nxt = 1'b1;
          seq_nxt = 1'b0;
          state_nxt = ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      idx_r <= 3'h0;
      seq_r <= 1'b0;
      recall_r <= 1'b0;
      write_r <= 1'b0;
      addr_r <= '0;
      wdata_r <= '0;
      rdata_r <= '0;
      rsp_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      idx_r <= idx_nxt;
      seq_r <= seq_nxt;
      recall_r <= recall_nxt;
      write_r <= write_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  // Chip select strobes each step, write strobe high
  assign pins.address_lines = addr_r;
  assign pins.chip_en_n = !in_acc;
  assign pins.write_en_n = !(in_acc && write_r);
  // Output enable left high on sequence steps to spare the bus
  assign pins.out_en_n = !(in_acc && !write_r && !seq_r);
  assign data_lines_o = wdata_r;
  assign data_lines_oe_n = !(in_acc && write_r);

  // Open drain: only ever pull low
  assign store_busy_line_n_o = 1'b0;
  assign store_busy_line_n_oe_n = (state_r != ST_PULSE);

  // ---------------------------------------------------------------
  // User side
  // ---------------------------------------------------------------
  assign cmd_ready = take;
  assign rsp_valid = rsp_r;
  assign rsp_rdata = rdata_r;
  assign busy = (state_r != ST_IDLE);

endmodule

`default_nettype wire

// ===== nv_store_host_chk.sv
// Purpose: Port-level checks on the nonvolatile SRAM host.
// Assumes: One clock domain, synchronous reset.
// Notes: Each access step is 4 cycles strobed low, then 1 cycle high.
`timescale 1ns/1ps
`default_nettype none

module nv_store_host_chk
  import nv_ctrl_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic cmd_valid, // Offered
  input wire logic cmd_ready, // Taken
  input wire cmd_t cmd, // Command
  input wire logic rsp_valid, // Done pulse
  input wire logic busy, // Busy
  input wire sram_pins_t pins, // Strobes
  input wire logic data_lines_oe_n, // Data drive
  input wire logic store_busy_line_n_i, // Line level
  input wire logic store_busy_line_n_o, // Line value
  input wire logic store_busy_line_n_oe_n // Line drive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic take;
  logic nvop;
  logic inseq_r;
  logic inseq_nxt;
  // Decoded take events
  assign take = cmd_valid && cmd_ready;
  assign nvop = take && (cmd.op == OP_STORE || cmd.op == OP_RECALL);
  assign inseq_nxt = nvop ? 1'b1 : (rsp_valid ? 1'b0 : inseq_r);
  // Marks a running store or recall
  always_ff @(posedge clk)
    if (rst)
      inseq_r <= 1'b0;
    else
      inseq_r <= inseq_nxt;

  AST_READ_WALK: assert property (take && cmd.op == OP_READ |=>
    (!pins.chip_en_n && !pins.out_en_n)[*4] ##1 (pins.chip_en_n && rsp_valid))
    else $error("read strobes wrong");
  AST_WRITE_WALK: assert property (take && cmd.op == OP_WRITE |=>
    (!pins.chip_en_n && !pins.write_en_n && !data_lines_oe_n)[*4] ##1 pins.write_en_n)
    else $error("write strobes wrong");
  AST_ADDR: assert property (take |=>
    pins.address_lines == ($past(nvop) ? SEQ_A0 : $past(cmd.addr)))
    else $error("address not loaded");
  AST_SEQ_FIRST: assert property (nvop |=>
    (!pins.chip_en_n && pins.address_lines == SEQ_A0)[*4] ##1 pins.chip_en_n
    ##1 (!pins.chip_en_n && pins.address_lines == SEQ_A1))
    else $error("sequence start wrong");
  AST_SEQ_STORE: assert property (take && cmd.op == OP_STORE |->
    ##26 (!pins.chip_en_n && pins.address_lines == SEQ_STORE))
    else $error("store terminator wrong");
  AST_SEQ_RECALL: assert property (take && cmd.op == OP_RECALL |->
    ##26 (!pins.chip_en_n && pins.address_lines == SEQ_RECALL))
    else $error("recall terminator wrong");
  AST_SEQ_READ: assert property (inseq_r |-> pins.write_en_n && data_lines_oe_n)
    else $error("write inside sequence");
  AST_LINE_PULSE: assert property (take && cmd.op == OP_LINE_STORE |=>
    (!store_busy_line_n_oe_n)[*5] ##1 store_busy_line_n_oe_n)
    else $error("line pulse wrong");
  AST_LINE_LOW: assert property (!store_busy_line_n_oe_n |-> !store_busy_line_n_o)
    else $error("line driven high");
  AST_REFUSE: assert property (cmd_ready |-> $past(store_busy_line_n_i, 2) && !busy)
    else $error("taken while line low");
endmodule

`default_nettype wire

// ===== nvsram_model.sv
// Purpose: Behavioural nonvolatile SRAM on the host's pins.
// Assumes: Accesses are framed by chip enable.
// Notes: Store and recall times are short stand-ins.
`timescale 1ns/1ps
`default_nettype none

module nvsram_model
  import nv_ctrl_pkg::*;
(
  input wire sram_pins_t pins, // Host strobes
  input wire logic [DATA_W-1:0] din, // Data from host
  input wire logic line_n, // Resolved busy line
  input wire logic holdup_low, // Holdup supply under switch threshold
  output logic [DATA_W-1:0] dout, // Data to host
  output logic drv // High pulls line low
);
  logic [DATA_W-1:0] mem [0:32767];
  logic [DATA_W-1:0] nv [0:32767];
  logic [DATA_W-1:0] last;
  logic [2:0] step;
  logic dirty;
  logic off;
  initial
  begin
    step = 3'h0;
    dirty = 1'b0;
    off = 1'b0;
    drv = 1'b0;
    last = 8'h00;
  end
  function automatic logic [ADDR_W-1:0] seq_at(input logic [2:0] s);
    case (s)
      3'h0: return SEQ_A0;
      3'h1: return SEQ_A1;
      3'h2: return SEQ_A2;
      3'h3: return SEQ_A3;
      default: return SEQ_A4;
    endcase
  endfunction
  task automatic do_store;
    off = 1'b1;
    drv = 1'b1;
    // Pull that fails to bring the line low abandons the store
    #1;
    if (line_n !== 1'b0)
    begin
      drv = 1'b0;
      off = 1'b0;
      return;
    end
    step = 3'h0;
    dirty = 1'b0;
    foreach (nv[i]) nv[i] = 8'hff;
    nv = mem;
    #200;
    drv = 1'b0;
    wait (line_n === 1'b1);
    off = 1'b0;
  endtask
  task automatic do_recall;
    off = 1'b1;
    step = 3'h0;
    foreach (mem[i]) mem[i] = 8'h00;
    mem = nv;
    #100;
    off = 1'b0;
  endtask
  always @(negedge pins.chip_en_n)
  begin
    #1;
    // Write with the line held low stores instead unless holdup is low; never writes
    if (!off && !pins.write_en_n && line_n === 1'b0)
    begin
      if (!holdup_low)
        do_store;
    end
    else if (!off && !pins.write_en_n)
    begin
      mem[pins.address_lines] = din;
      dirty = 1'b1;
      step = 3'h0;
    end
    else if (!off && !holdup_low && step == 3'h5 && pins.address_lines == SEQ_STORE)
      do_store;
    else if (!off && step == 3'h5 && pins.address_lines == SEQ_RECALL)
      do_recall;
    else if (!off)
      step = (step < 3'h5 && pins.address_lines == seq_at(step)) ? step + 3'h1 :
        {2'h0, pins.address_lines == SEQ_A0};
  end
  always @(negedge line_n)
    if (!drv)
    begin
      #50;
      if (line_n === 1'b0 && dirty && !holdup_low)
        do_store;
      else if (line_n === 1'b0)
      begin
        off = 1'b1;
        wait (line_n === 1'b1);
        off = 1'b0;
      end
    end
  // Undriven bus shows inverted old data, never a settled guess
  assign dout = (!pins.chip_en_n && !pins.out_en_n && pins.write_en_n && !off) ?
    mem[pins.address_lines] : ~last;
  always @(posedge pins.out_en_n) last = mem[pins.address_lines];
endmodule

`default_nettype wire

// ===== nv_store_host_tb.sv
// Purpose: Self-checking bench for the nonvolatile SRAM host.
// Assumes: Model answers well inside the shortened waits.
// Notes: Store wait shortened to 20 cycles, recall to 10.
`timescale 1ns/1ps
`default_nettype none

module nv_store_host_tb
  import nv_ctrl_pkg::*;
;
  logic clk = 1'b0;
  logic holdup_low = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  cmd_t cmd = '0;
  logic ext_low = 1'b0;
  logic cmd_ready, rsp_valid, busy, d_oe_n, l_o, l_oe_n, drv, line_n;
  logic [DATA_W-1:0] rsp_rdata, d_o, m_o, d_i, rd;
  sram_pins_t pins;
  int miscompares = 0;
  int compares = 0;
  // Open-drain line with weak pull-up; shared data pins
  assign line_n = (l_oe_n ? 1'b1 : l_o) & !drv & !ext_low;
  assign d_i = d_oe_n ? m_o : d_o;
  always #12.5 clk = ~clk;

  nv_store_host #(.STORE_WAIT(20), .RECALL_WAIT(10)) DUT (.clk(clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .busy(busy), .pins(pins), .data_lines_i(d_i),
    .data_lines_o(d_o), .data_lines_oe_n(d_oe_n), .store_busy_line_n_i(line_n),
    .store_busy_line_n_o(l_o), .store_busy_line_n_oe_n(l_oe_n));
  nvsram_model u_mem (.pins(pins), .din(d_o), .line_n(line_n), .holdup_low(holdup_low),
    .dout(m_o), .drv(drv));

  task automatic print_verdict;
    if (miscompares == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One command, waits for take and, except for writes, for the completion pulse
  task automatic run(input op_t op, input logic [14:0] a, input logic [7:0] wd);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd <= '{op: op, addr: a, wdata: wd};
    do
    begin
      @(posedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 200);
    chk1(cmd_ready, 1'b1);
    cmd_valid <= 1'b0;
    n = 0;
    if (op != OP_WRITE)
      do
      begin
        @(posedge clk);
        n++;
      end while (rsp_valid !== 1'b1 && n < 2000);
    else
      @(posedge clk);
    rd = rsp_rdata;
    if (op != OP_WRITE)
      chk1(rsp_valid, 1'b1);
  endtask
  // Back-to-back writes, then reads at the address extremes
  task automatic s_wr_rd;
    run(OP_WRITE, 15'h0000, 8'ha5);
    run(OP_WRITE, 15'h7fff, 8'h5a);
    run(OP_READ, 15'h0000, 8'h00);
    chk8(rd, 8'ha5);
    run(OP_READ, 15'h7fff, 8'h00);
    chk8(rd, 8'h5a);
  endtask
  // Store, overwrite, recall brings the stored byte back
  task automatic s_store_recall;
    run(OP_WRITE, 15'h0040, 8'h3c);
    run(OP_STORE, 15'h0000, 8'h00);
    run(OP_WRITE, 15'h0040, 8'hc3);
    run(OP_READ, 15'h0040, 8'h00);
    chk8(rd, 8'hc3);
    run(OP_RECALL, 15'h0000, 8'h00);
    run(OP_READ, 15'h0040, 8'h00);
    chk8(rd, 8'h3c);
    run(OP_READ, 15'h7fff, 8'h00);
    chk8(rd, 8'h5a);
  endtask
  // Line-requested store keeps the byte written before it
  task automatic s_line_store;
    run(OP_WRITE, 15'h0041, 8'h96);
    run(OP_LINE_STORE, 15'h0000, 8'h00);
    run(OP_WRITE, 15'h0041, 8'h69);
    run(OP_RECALL, 15'h0000, 8'h00);
    run(OP_READ, 15'h0041, 8'h00);
    chk8(rd, 8'h96);
  endtask
  // Outside logic holds the line: host must refuse commands
  task automatic s_ext_hold;
    ext_low <= 1'b1;
    repeat (3) @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= '{op: OP_READ, addr: 15'h0041, wdata: 8'h00};
    repeat (6) @(posedge clk);
    chk1(cmd_ready, 1'b0);
    chk1(busy, 1'b0);
    cmd_valid <= 1'b0;
    ext_low <= 1'b0;
    @(posedge clk);
    run(OP_READ, 15'h0041, 8'h00);
    chk8(rd, 8'h96);
  endtask
  // Store below the capacitor threshold leaves the old image in place
  task automatic s_holdup_low;
    holdup_low <= 1'b1;
    run(OP_WRITE, 15'h0041, 8'h77);
    run(OP_STORE, 15'h0000, 8'h00);
    holdup_low <= 1'b0;
    run(OP_RECALL, 15'h0000, 8'h00);
    run(OP_READ, 15'h0041, 8'h00);
    chk8(rd, 8'h96);
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    s_wr_rd;
    s_store_recall;
    s_line_store;
    s_ext_hold;
    s_holdup_low;
    print_verdict;
  end
  // Tests need a few hundred cycles; 40000 cycles means a hang
  initial
  begin
    #1000000;
    miscompares++;
    print_verdict;
  end
endmodule

bind nv_store_host nv_store_host_chk u_chk (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid), .busy(busy), .pins(pins),
  .data_lines_oe_n(data_lines_oe_n), .store_busy_line_n_i(store_busy_line_n_i),
  .store_busy_line_n_o(store_busy_line_n_o),
  .store_busy_line_n_oe_n(store_busy_line_n_oe_n));

`default_nettype wire
